// file: hw/sbt_timer.sv
// Sixteen-bit interval timer and event counter with APB register slave
`timescale 1ns/100ps
module sbt_timer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire sbt_pkg::sbt_apb_req_t apb_req,
  input wire sbt_pkg::sbt_src_t src_in,
  input wire sbt_pkg::sbt_power_t power_in,
  output logic [sbt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  typedef struct packed {
    logic [sbt_pkg::CNT_W-1:0] control;
    logic [sbt_pkg::CNT_W-1:0] count;
    logic [sbt_pkg::CNT_W-1:0] period;
    logic [sbt_pkg::CNT_W-1:0] hold;
    logic pend;
    logic [sbt_pkg::PRE_W-1:0] pre_cnt;
    logic ext_s1;
    logic ext_s2;
    logic s2_prev;
    logic raw_prev;
    logic gate_prev;
    logic [sbt_pkg::EV_W-1:0] status;
    logic [sbt_pkg::EV_W-1:0] mask;
    logic pready;
    logic pslverr;
    logic [sbt_pkg::DATA_W-1:0] prdata;
    logic irq;
  } sbt_state_t;

  sbt_state_t state_reg;
  sbt_state_t state_next;

  function automatic logic [sbt_pkg::DATA_W-1:0] alias_apply(
    input logic [sbt_pkg::DATA_W-1:0] old_val,
    input logic [sbt_pkg::DATA_W-1:0] wdata,
    input sbt_pkg::sbt_alias_t kind,
    input logic [sbt_pkg::DATA_W-1:0] wmask
  );
    logic [sbt_pkg::DATA_W-1:0] res;
    res = old_val;
    case (kind)
      sbt_pkg::ALIAS_WRITE: res = wdata;
      sbt_pkg::ALIAS_CLR: res = old_val & ~wdata;
      sbt_pkg::ALIAS_SET: res = old_val | wdata;
      sbt_pkg::ALIAS_INV: res = old_val ^ wdata;
      default: res = old_val;
    endcase
    return res & wmask;
  endfunction : alias_apply

  function automatic logic [sbt_pkg::PRE_W-1:0] prescale_term(input logic [1:0] sel);
    logic [sbt_pkg::PRE_W-1:0] t;
    t = sbt_pkg::PRE_TERM_1;
    case (sel)
      2'h0: t = sbt_pkg::PRE_TERM_1;
      2'h1: t = sbt_pkg::PRE_TERM_8;
      2'h2: t = sbt_pkg::PRE_TERM_64;
      default: t = sbt_pkg::PRE_TERM_256;
    endcase
    return t;
  endfunction : prescale_term

  logic run_en;
  logic idle_halt;
  logic write_block;
  logic gate_en;
  logic src_ext;
  logic ext_sync;
  logic async_mode;
  logic raw_in;
  logic ext_edge;
  logic in_edge;
  logic running;
  logic tick;
  logic [sbt_pkg::EV_W-1:0] ev;
  logic [sbt_pkg::EV_W-1:0] ev_clr;
  logic access;
  logic done;
  logic addr_ok;
  logic [7:0] group;
  sbt_pkg::sbt_alias_t kind;
  logic [sbt_pkg::DATA_W-1:0] ctrl_rd;
  logic [sbt_pkg::DATA_W-1:0] rd_val;
  logic rd_err;
  logic [sbt_pkg::DATA_W-1:0] wr_val;
  logic [sbt_pkg::CNT_W-1:0] pre_next_term;

  always_comb begin
    state_next = state_reg;
    ev = '0;
    ev_clr = '0;
    tick = 1'b0;
    wr_val = '0;
    rd_val = '0;
    rd_err = 1'b0;
    pre_next_term = '0;

    run_en = state_reg.control[sbt_pkg::BIT_ENABLE];
    idle_halt = state_reg.control[sbt_pkg::BIT_IDLE_HALT];
    write_block = state_reg.control[sbt_pkg::BIT_ASYNC_WRITE_BLOCK];
    gate_en = state_reg.control[sbt_pkg::BIT_GATE_ACC_EN];
    src_ext = state_reg.control[sbt_pkg::BIT_SOURCE_SEL];
    ext_sync = state_reg.control[sbt_pkg::BIT_EXT_SYNC];
    async_mode = src_ext & ~ext_sync;

    // External source mux; reserved code never counts
    case (sbt_pkg::sbt_ext_src_t'(state_reg.control[sbt_pkg::BIT_EXT_SRC_HI:sbt_pkg::BIT_EXT_SRC_LO]))
      sbt_pkg::SRC_SECONDARY_OSC: raw_in = src_in.secondary_osc;
      sbt_pkg::SRC_EXT_COUNT_PIN: raw_in = src_in.ext_count_pin;
      sbt_pkg::SRC_LOW_POWER_RC: raw_in = src_in.low_power_rc;
      default: raw_in = 1'b0;
    endcase

    // Two-stage resync path; the first stage feeds only the second
    state_next.ext_s1 = raw_in;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.s2_prev = state_reg.ext_s2;
    state_next.raw_prev = raw_in;
    // Unsynchronised path costs two fewer cycles of latency
    ext_edge = ext_sync ? (state_reg.ext_s2 & ~state_reg.s2_prev) : (raw_in & ~state_reg.raw_prev);

    // Internal source is every core clock, optionally qualified by the gate
    if (src_ext) begin
      in_edge = ext_edge;
    end else if (gate_en) begin
      in_edge = src_in.gate_in;
    end else begin
      in_edge = 1'b1;
    end

    // Sleep stops the bus clock, so only the async external mode survives
    running = run_en
      & ~(power_in.idle_mode & idle_halt)
      & ~(power_in.sleep_mode & ~async_mode);

    state_next.gate_prev = src_in.gate_in;
    if (~src_ext & gate_en & state_reg.gate_prev & ~src_in.gate_in) begin
      ev[sbt_pkg::EV_GATE_FALL] = 1'b1;
    end

    pre_next_term = {8'h00, prescale_term(state_reg.control[sbt_pkg::BIT_PRESCALE_HI:sbt_pkg::BIT_PRESCALE_LO])};
    if (running & in_edge) begin
      if ({8'h00, state_reg.pre_cnt} >= pre_next_term) begin
        state_next.pre_cnt = '0;
        tick = 1'b1;
      end else begin
        state_next.pre_cnt = state_reg.pre_cnt + 8'h01;
      end
    end
    if (~run_en) begin
      state_next.pre_cnt = '0;
    end

    if (tick) begin
      if (state_reg.count == state_reg.period) begin
        state_next.count = '0;
        ev[sbt_pkg::EV_PERIOD] = 1'b1;
      end else begin
        state_next.count = state_reg.count + 16'h0001;
      end
    end

    // A held async write lands on the next source edge, or at once on leaving async mode
    if (state_reg.pend & (~async_mode | (raw_in & ~state_reg.raw_prev))) begin
      state_next.count = state_reg.hold;
      state_next.pend = 1'b0;
    end

    // APB slave: one wait state, then pready; write lands at the completing edge
    access = apb_req.psel & apb_req.penable;
    done = access & state_reg.pready;
    group = apb_req.paddr[sbt_pkg::ADDR_W-1:4];
    kind = sbt_pkg::sbt_alias_t'(apb_req.paddr[3:2]);
    addr_ok = (apb_req.paddr[1:0] == 2'h0);

    ctrl_rd = {16'h0000, state_reg.control};
    ctrl_rd[sbt_pkg::BIT_ASYNC_WRITE_PENDING] = state_reg.pend & async_mode;

    if (~addr_ok) begin
      rd_err = 1'b1;
    end else if (group == sbt_pkg::OFF_CONTROL[sbt_pkg::ADDR_W-1:4]) begin
      rd_val = ctrl_rd;
    end else if (group == sbt_pkg::OFF_COUNT[sbt_pkg::ADDR_W-1:4]) begin
      rd_val = {16'h0000, state_reg.count};
    end else if (group == sbt_pkg::OFF_PERIOD[sbt_pkg::ADDR_W-1:4]) begin
      rd_val = {16'h0000, state_reg.period};
    end else if ((apb_req.paddr == sbt_pkg::OFF_IRQ_STATUS)) begin
      rd_val = {30'h00000000, state_reg.status};
    end else if ((apb_req.paddr == sbt_pkg::OFF_IRQ_MASK)) begin
      rd_val = {30'h00000000, state_reg.mask};
    end else begin
      rd_err = 1'b1;
    end

    state_next.pready = access & ~state_reg.pready;
    if (access & ~state_reg.pready) begin
      state_next.pslverr = rd_err;
      state_next.prdata = (apb_req.pwrite | rd_err) ? 32'h00000000 : rd_val;
    end else begin
      // Error flag stands only with its pready pulse
      state_next.pslverr = 1'b0;
    end

    if (done & apb_req.pwrite & ~rd_err) begin
      if (group == sbt_pkg::OFF_CONTROL[sbt_pkg::ADDR_W-1:4]) begin
        wr_val = alias_apply({16'h0000, state_reg.control}, apb_req.pwdata, kind, sbt_pkg::CONTROL_WMASK);
        state_next.control = wr_val[sbt_pkg::CNT_W-1:0];
      end else if (group == sbt_pkg::OFF_COUNT[sbt_pkg::ADDR_W-1:4]) begin
        wr_val = alias_apply({16'h0000, state_reg.count}, apb_req.pwdata, kind, sbt_pkg::CNT_WMASK);
        if (async_mode) begin
          if (~(state_reg.pend & write_block)) begin
            state_next.hold = wr_val[sbt_pkg::CNT_W-1:0];
            state_next.pend = 1'b1;
          end
        end else begin
          state_next.count = wr_val[sbt_pkg::CNT_W-1:0];
        end
      end else if (group == sbt_pkg::OFF_PERIOD[sbt_pkg::ADDR_W-1:4]) begin
        wr_val = alias_apply({16'h0000, state_reg.period}, apb_req.pwdata, kind, sbt_pkg::CNT_WMASK);
        state_next.period = wr_val[sbt_pkg::CNT_W-1:0];
      end else if (apb_req.paddr == sbt_pkg::OFF_IRQ_STATUS) begin
        ev_clr = apb_req.pwdata[sbt_pkg::EV_W-1:0];
      end else if (apb_req.paddr == sbt_pkg::OFF_IRQ_MASK) begin
        state_next.mask = apb_req.pwdata[sbt_pkg::EV_W-1:0];
      end
    end

    // A new event beats a same-cycle clear
    state_next.status = (state_reg.status & ~ev_clr) | ev;
    state_next.irq = |(state_next.status & state_next.mask);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.control <= sbt_pkg::CONTROL_RESET;
      state_reg.count <= sbt_pkg::COUNT_RESET;
      state_reg.period <= sbt_pkg::PERIOD_RESET;
      state_reg.hold <= sbt_pkg::COUNT_RESET;
      state_reg.pend <= 1'b0;
      state_reg.pre_cnt <= '0;
      state_reg.ext_s1 <= 1'b0;
      state_reg.ext_s2 <= 1'b0;
      state_reg.s2_prev <= 1'b0;
      state_reg.raw_prev <= 1'b0;
      state_reg.gate_prev <= 1'b0;
      state_reg.status <= sbt_pkg::EV_RESET;
      state_reg.mask <= sbt_pkg::EV_RESET;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 32'h00000000;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq = state_reg.irq;

endmodule : sbt_timer

// file: hw/sbt_pkg.sv
// Package: constants, field layout and carrier types of the interval timer
package sbt_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRE_W = 8;
  localparam int unsigned EV_W = 2;

  // Register byte offsets; each of the first three has clear/set/invert aliases
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h040;

  // Control field positions
  localparam int unsigned BIT_ENABLE = 15;
  localparam int unsigned BIT_IDLE_HALT = 13;
  localparam int unsigned BIT_ASYNC_WRITE_BLOCK = 12;
  localparam int unsigned BIT_ASYNC_WRITE_PENDING = 11;
  localparam int unsigned BIT_EXT_SRC_HI = 9;
  localparam int unsigned BIT_EXT_SRC_LO = 8;
  localparam int unsigned BIT_GATE_ACC_EN = 7;
  localparam int unsigned BIT_PRESCALE_HI = 5;
  localparam int unsigned BIT_PRESCALE_LO = 4;
  localparam int unsigned BIT_EXT_SYNC = 2;
  localparam int unsigned BIT_SOURCE_SEL = 1;

  localparam logic [DATA_W-1:0] CONTROL_WMASK = 32'h0000B3B6;
  localparam logic [DATA_W-1:0] CNT_WMASK = 32'h0000FFFF;
  localparam logic [DATA_W-1:0] EV_WMASK = 32'h00000003;

  // Reset values
  localparam logic [CNT_W-1:0] CONTROL_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [PRE_W-1:0] PRE_TERM_1 = 8'h00;
  localparam logic [PRE_W-1:0] PRE_TERM_8 = 8'h07;
  localparam logic [PRE_W-1:0] PRE_TERM_64 = 8'h3F;
  localparam logic [PRE_W-1:0] PRE_TERM_256 = 8'hFF;

  // Event bit positions in status and mask
  localparam int unsigned EV_PERIOD = 0;
  localparam int unsigned EV_GATE_FALL = 1;

  typedef enum logic [1:0] {ALIAS_WRITE, ALIAS_CLR, ALIAS_SET, ALIAS_INV} sbt_alias_t;
  typedef enum logic [1:0] {SRC_SECONDARY_OSC, SRC_EXT_COUNT_PIN, SRC_LOW_POWER_RC, SRC_RESERVED} sbt_ext_src_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } sbt_apb_req_t;

  typedef struct packed {
    logic secondary_osc;
    logic ext_count_pin;
    logic low_power_rc;
    logic gate_in;
  } sbt_src_t;

  typedef struct packed {
    logic idle_mode;
    logic sleep_mode;
  } sbt_power_t;
endpackage : sbt_pkg

// file: verification/sbt_timer_checker.sv
// Checker: bus and interrupt relations at the timer ports
`timescale 1ns/100ps
module sbt_timer_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire sbt_pkg::sbt_apb_req_t apb_req,
  input wire sbt_pkg::sbt_src_t src_in,
  input wire sbt_pkg::sbt_power_t power_in,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic acc;
  logic rd_done;
  logic wr_done;
  assign acc = apb_req.psel && apb_req.penable;
  assign rd_done = pready && !apb_req.pwrite && apb_req.paddr[1:0] == 2'h0;
  assign wr_done = pready && apb_req.pwrite;
  property p_ready_wait;
    acc && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_err_align;
    acc && !pready && apb_req.paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  a_err_align: assert property (p_err_align) else $error("misaligned not refused");
  property p_err_ready;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("bad error response");
  property p_ctrl_read;
    rd_done && apb_req.paddr[11:4] == 8'h00 |-> (prdata & ~32'h0000BBB6) == 32'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control reserved bits set");
  property p_cnt_read;
    rd_done && apb_req.paddr[11:4] inside {8'h01, 8'h02} |-> prdata[31:16] == 16'h0;
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count upper bits set");
  property p_irq_fall;
    $fell(irq) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_rdata_hold;
    $changed(prdata) |-> pready;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  c_err: cover property (acc && pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_read: cover property (rd_done);
endmodule : sbt_timer_checker

// file: verification/sbt_timer_test.sv
// Testbench: register-level tests of the interval timer
`timescale 1ns/100ps
module sbt_timer_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  sbt_pkg::sbt_apb_req_t req = '0;
  sbt_pkg::sbt_src_t src = '0;
  sbt_pkg::sbt_power_t pw = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] q;
  logic e;
  int mismatches = 0;
  int checked = 0;
  always #50 core_clk = ~core_clk;
  sbt_timer u_dut (.core_clk(core_clk), .arst_n(arst_n), .apb_req(req), .src_in(src), .power_in(pw),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Request held until pready seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  // Start and stop latency is not fixed, so a window is accepted
  task automatic rng(input logic [11:0] a, input int lo, input int hi);
    xfer(1'b0, a, 32'h0);
    chk({31'h0, int'(q) >= lo && int'(q) <= hi}, 32'h1);
  endtask : rng
  task automatic irqchk(input logic x);
    repeat (2) @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, x});
  endtask : irqchk
  task automatic pulse(input logic [3:0] m);
    repeat (4) @(posedge core_clk);
    src <= src | m;
    repeat (4) @(posedge core_clk);
    src <= src & ~m;
  endtask : pulse
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    int d;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    rd(12'h020, 32'h0000FFFF);
    rd(12'h030, 32'h0);
    rd(12'h040, 32'h0);
    wr(12'h000, 32'hFFFFFFFF);
    rd(12'h000, 32'h0000B3B6);
    wr(12'h004, 32'h00008000);
    rd(12'h000, 32'h000033B6);
    wr(12'h00C, 32'h00000030);
    rd(12'h00C, 32'h00003386);
    wr(12'h008, 32'h00000041);
    rd(12'h000, 32'h00003386);
    xfer(1'b0, 12'h100, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 12'h002, 32'h1);
    chk({31'h0, e}, 32'h1);
    wr(12'h000, 32'h0);
    $display("register access done");
    wr(12'h020, 32'h4);
    wr(12'h040, 32'h1);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h8000);
    while (irq !== 1'b1) @(negedge core_clk);
    wr(12'h000, 32'h0);
    rd(12'h030, 32'h1);
    rng(12'h010, 0, 4);
    wr(12'h040, 32'h0);
    irqchk(1'b0);
    wr(12'h040, 32'h1);
    irqchk(1'b1);
    wr(12'h030, 32'h1);
    irqchk(1'b0);
    wr(12'h020, 32'hFFFF);
    $display("interval interrupt done");
    for (int p = 0; p < 4; p++) begin
      d = (p == 3) ? 256 : 1 << (3 * p);
      wr(12'h010, 32'h0);
      wr(12'h000, 32'h8000 | 32'(p << 4));
      repeat (8 * d) @(posedge core_clk);
      wr(12'h000, 32'h0);
      rng(12'h010, (8 * d + 4) / d - 2, (8 * d + 4) / d + 2);
    end
    $display("prescale done");
    wr(12'h040, 32'h2);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h8080);
    src.gate_in <= 1'b1;
    repeat (20) @(posedge core_clk);
    src.gate_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr(12'h000, 32'h0);
    rng(12'h010, 19, 21);
    rd(12'h030, 32'h2);
    irqchk(1'b1);
    wr(12'h030, 32'h3);
    $display("gated done");
    // Reserved source code toggles all three external sources (not gate_in) and must stay at zero
    for (int s = 0; s < 4; s++) begin
      wr(12'h010, 32'h0);
      wr(12'h000, 32'h8006 | 32'(s << 8));
      repeat (5) pulse((s == 3) ? 4'hE : 4'h8 >> s);
      wr(12'h000, 32'h0);
      rd(12'h010, (s == 3) ? 32'h0 : 32'h5);
    end
    $display("external sources done");
    wr(12'h000, 32'h9102);
    wr(12'h010, 32'h5);
    rd(12'h000, 32'h9902);
    wr(12'h010, 32'h9);
    pulse(4'h4);
    rd(12'h000, 32'h9102);
    wr(12'h000, 32'h1102);
    rd(12'h010, 32'h5);
    wr(12'h000, 32'h0102);
    wr(12'h010, 32'h3);
    wr(12'h010, 32'h7);
    pulse(4'h4);
    rd(12'h010, 32'h7);
    wr(12'h000, 32'h0);
    $display("async write done");
    pw.idle_mode <= 1'b1;
    wr(12'h010, 32'h0);
    wr(12'h000, 32'hA000);
    repeat (20) @(posedge core_clk);
    wr(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    wr(12'h000, 32'h8000);
    repeat (20) @(posedge core_clk);
    wr(12'h000, 32'h0);
    rng(12'h010, 22, 26);
    $display("idle done");
    pw <= '{idle_mode: 1'b0, sleep_mode: 1'b1};
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h8000);
    repeat (20) @(posedge core_clk);
    wr(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    pw <= '0;
    $display("sleep done");
    stop_test();
  end
endmodule : sbt_timer_test
bind sbt_timer sbt_timer_checker u_chk (.core_clk(core_clk), .arst_n(arst_n), .apb_req(apb_req),
  .src_in(src_in), .power_in(power_in), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
